/* File: src/otpac_device.sv */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module otpac_device #(
   parameter int PROGRAM_CYC   = otpac_pkg::PROGRAM_CYC,
   parameter int OTP_BUSY_CYC  = otpac_pkg::OTP_BUSY_CYC,
   parameter int PAGE_READ_CYC = otpac_pkg::PAGE_READ_CYC
) (
   // Clock and reset.
   input  wire logic  clk_i,
   input  wire logic  rst_b_i,
   // Link.
   otpac_if.dev       nand_if,
   // Mode view.
   output logic       otp_mode_o,
   output logic       sync_if_o,
   output logic       protected_o
);
   if (PROGRAM_CYC < 1 || OTP_BUSY_CYC < 1 || PAGE_READ_CYC < 1 ||
       PROGRAM_CYC >= 2**21 || OTP_BUSY_CYC >= 2**21 || PAGE_READ_CYC >= 2**21) begin : g_bad_cnt
      $error("otpac_device: counts must fit the busy timer");
   end

   typedef enum logic [2:0] {
      OTPAC_IDLE = 3'b000,
      OTPAC_ADDR = 3'b001,
      OTPAC_DATA = 3'b011,
      OTPAC_FEAT = 3'b010,
      OTPAC_WCOL = 3'b110,
      OTPAC_RCOL = 3'b111
   } otpac_dst_t;

   typedef enum logic [1:0] {
      OTPAC_OP_READ = 2'b00,
      OTPAC_OP_PROG = 2'b01
   } otpac_op_t;

   otpac_dst_t  st_q;
   otpac_op_t   op_q;
   logic [2:0]  acnt_q;
   logic [7:0]  col_lo_q;
   logic [13:0] col_q;
   logic [7:0]  page_q;
   logic [7:0]  block_q;
   logic [7:0]  first_q;
   logic        first_seen_q;
   logic [7:0]  feat_addr_q;
   logic [7:0]  feat_p1_q;
   logic        feat_nz_q;
   logic [20:0] busy_q;
   logic        busy_prog_q;
   logic        status_out_q;
   logic [7:0]  status_q;
   logic [7:0]  dout_q;
   logic        prot_pend_q;
   logic [7:0]  mem [0:31][0:15];

   logic       cmd_w;
   logic       adr_w;
   logic       din_w;
   logic [7:0] d;
   // Status polling must still reach the die while it is busy.
   assign cmd_w = nand_if.we && nand_if.cle &&
                  (busy_q == '0 || nand_if.dq_h2d == otpac_pkg::CMD_STATUS);
   assign adr_w = nand_if.we && nand_if.ale && busy_q == '0;
   assign din_w = nand_if.we && !nand_if.cle && !nand_if.ale && busy_q == '0;
   assign d     = nand_if.dq_h2d;

   function automatic logic page_ok(input logic [7:0] p);
      page_ok = p >= otpac_pkg::START_PAGE &&
                p < otpac_pkg::START_PAGE + 8'(otpac_pkg::OTP_PAGES);
   endfunction : page_ok

   // Command decoder.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= OTPAC_IDLE;
         op_q <= OTPAC_OP_READ;
         acnt_q <= 3'h0;
         col_lo_q <= 8'h00;
         col_q <= 14'h0000;
         page_q <= 8'h00;
         block_q <= 8'h00;
         feat_addr_q <= 8'h00;
         feat_p1_q <= 8'h00;
         feat_nz_q <= 1'b0;
         status_out_q <= 1'b0;
      end else if (cmd_w) begin
         case (d)
            otpac_pkg::CMD_READ1: begin
               status_out_q <= 1'b0;
               if (st_q == OTPAC_IDLE) begin
                  st_q <= OTPAC_ADDR;
                  op_q <= OTPAC_OP_READ;
                  acnt_q <= 3'h0;
               end
            end
            otpac_pkg::CMD_PROG1: begin
               st_q <= OTPAC_ADDR;
               op_q <= OTPAC_OP_PROG;
               acnt_q <= 3'h0;
            end
            otpac_pkg::CMD_WCOL: begin
               if (st_q == OTPAC_DATA) begin
                  st_q <= OTPAC_WCOL;
                  acnt_q <= 3'h0;
               end
            end
            otpac_pkg::CMD_RCOL1: begin
               st_q <= OTPAC_RCOL;
               acnt_q <= 3'h0;
            end
            otpac_pkg::CMD_STATUS: status_out_q <= 1'b1;
            otpac_pkg::CMD_SETFEAT: begin
               st_q <= OTPAC_FEAT;
               acnt_q <= 3'h0;
               feat_nz_q <= 1'b0;
            end
            otpac_pkg::CMD_READ2: begin
               st_q <= OTPAC_IDLE;
               status_out_q <= 1'b0;
            end
            otpac_pkg::CMD_PROG2: begin
               st_q <= OTPAC_IDLE;
               status_out_q <= 1'b0;
               col_q <= 14'h0000;
            end
            default: begin
               st_q <= OTPAC_IDLE;
            end
         endcase
      end else if (adr_w) begin
         acnt_q <= acnt_q + 3'h1;
         case (st_q)
            OTPAC_ADDR, OTPAC_WCOL, OTPAC_RCOL: begin
               if (acnt_q == 3'h0) col_lo_q <= d;
               if (acnt_q == 3'h1) col_q <= {d[5:0], col_lo_q};
               if (acnt_q == 3'h2) page_q <= d;
               if (acnt_q == 3'h3) block_q <= d;
               if (acnt_q == 3'h1 && st_q == OTPAC_WCOL) st_q <= OTPAC_DATA;
            end
            OTPAC_FEAT: begin
               feat_addr_q <= d;
               acnt_q <= 3'h0;
            end
            default: ;
         endcase
      end else if (din_w) begin
         if (st_q == OTPAC_ADDR && op_q == OTPAC_OP_PROG) st_q <= OTPAC_DATA;
         if (st_q == OTPAC_FEAT) begin
            acnt_q <= acnt_q + 3'h1;
            if (acnt_q == 3'h0) feat_p1_q <= d;
            else if (d != 8'h00) feat_nz_q <= 1'b1;
         end
         if (st_q == OTPAC_ADDR || st_q == OTPAC_DATA) col_q <= col_q + 14'h0001;
      end else if (nand_if.re && !status_out_q) begin
         col_q <= col_q + 14'h0001;
      end
   end

   // First data byte of a program, used to spot a protect request.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         first_q <= 8'hff;
         first_seen_q <= 1'b0;
      end else if (cmd_w && d == otpac_pkg::CMD_PROG1) begin
         first_seen_q <= 1'b0;
      end else if (din_w && !first_seen_q && st_q != OTPAC_FEAT) begin
         first_q <= d;
         first_seen_q <= 1'b1;
      end
   end

   // Mode: features, resets and the sync interface flag.
   logic feat_done_w;
   logic prog_go_w;
   logic is_prot_w;
   assign feat_done_w = din_w && st_q == OTPAC_FEAT && acnt_q == 3'h3 &&
                        feat_addr_q == otpac_pkg::FEAT_OTP;
   assign prog_go_w   = cmd_w && d == otpac_pkg::CMD_PROG2 && otp_mode_o &&
                        op_q == OTPAC_OP_PROG;
   assign is_prot_w   = page_q == otpac_pkg::PROTECT_PAGE && col_q == 14'h0001 &&
                        block_q == 8'h00 && first_q == 8'h00;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         otp_mode_o <= 1'b0;
         sync_if_o  <= 1'b0;
      end else if (cmd_w && d == otpac_pkg::CMD_SRESET) begin
         otp_mode_o <= 1'b0;
         sync_if_o  <= 1'b1;
      end else if (cmd_w && d == otpac_pkg::CMD_RESET) begin
         otp_mode_o <= 1'b0;
         sync_if_o  <= 1'b0;
      end else if (feat_done_w) begin
         if (feat_p1_q == otpac_pkg::FEAT_OTP_ON && !feat_nz_q && d == 8'h00) begin
            otp_mode_o <= 1'b1;
         end else if (feat_p1_q == 8'h00 && !feat_nz_q && d == 8'h00) begin
            otp_mode_o <= 1'b0;
         end
      end
   end

   // Busy timer and status register.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_q <= '0;
         busy_prog_q <= 1'b0;
         prot_pend_q <= 1'b0;
         protected_o <= 1'b0;
         status_q <= 8'he0;
      end else if (busy_q != '0) begin
         busy_q <= busy_q - 21'h1;
         if (busy_q == 21'h1 && prot_pend_q) begin
            protected_o <= 1'b1;
            prot_pend_q <= 1'b0;
         end
         if (busy_q == 21'h1) begin
            status_q[otpac_pkg::ST_RDY]  <= 1'b1;
            status_q[otpac_pkg::ST_ARRAY_READY_FLAG] <= 1'b1;
         end
      end else if (prog_go_w) begin
         // Ready bits follow the pin, so the final value is complete when busy ends.
         if (protected_o && page_ok(page_q) || protected_o && is_prot_w) begin
            busy_q <= 21'(OTP_BUSY_CYC);
            status_q <= otpac_pkg::STATUS_LOCKED;
            status_q[otpac_pkg::ST_RDY]  <= 1'b0;
            status_q[otpac_pkg::ST_ARRAY_READY_FLAG] <= 1'b0;
         end else if (!page_ok(page_q) && !is_prot_w) begin
            busy_q <= 21'(OTP_BUSY_CYC);
            status_q <= 8'h00;
         end else begin
            busy_q <= 21'(PROGRAM_CYC);
            status_q <= 8'h80;
            prot_pend_q <= is_prot_w;
         end
      end else if (cmd_w && d == otpac_pkg::CMD_READ2 && otp_mode_o) begin
         busy_q <= 21'(PAGE_READ_CYC);
         status_q <= 8'h80;
      end
   end

   // Cache, written on data input, read back on data output.
   // Reset stands in for the erased state; a real array keeps its contents.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int pg = 0; pg < 32; pg++) begin
            for (int cb = 0; cb < 16; cb++) begin
               mem[pg][cb] <= 8'hff;
            end
         end
      end else if (din_w && op_q == OTPAC_OP_PROG && (st_q == OTPAC_ADDR || st_q == OTPAC_DATA) &&
                   page_ok(page_q) && !protected_o) begin
         mem[page_q[4:0]][col_q[3:0]] <= mem[page_q[4:0]][col_q[3:0]] & d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) dout_q <= 8'h00;
      else if (status_out_q) dout_q <= status_q;
      else dout_q <= page_ok(page_q) ? mem[page_q[4:0]][col_q[3:0]] : 8'hff;
   end

   assign nand_if.dq_d2h       = dout_q;
   assign nand_if.dq_d2h_oe    = nand_if.re;
   assign nand_if.ready_busy_n = busy_q == '0;
endmodule : otpac_device
`default_nettype wire

/* File: src/otpac_pkg.sv */
// Behaviour
// - Sync reset FCh leaves OTP mode, keeps sync.
// - Thirty usable pages starting at page 02h.
// - Page 01h is the protect page.
// - Host programs each page at most twice.
// - Program is 80h, five addresses, data, 10h.
// - Busy low for program time; ready flag follows.
// - Host polls only with 70h, never 78h.
// - Host checks fail flag after program ready; tb skips it after the 1Fh and 20h programs.
// - 85h during data input moves input column.
// - Program after protection: short busy, status 60h.
// - Protect is 80h, column 0, page 01h, 00h, 10h.
// - Repeat protect: short busy, status 60h.
// - Read 00h, address, 30h; busy for read time.
// - After status polling, 00h restores data output.
// - Each further page needs a full read sequence.
// - 05h-E0h accepted in read; no 06h-E0h.
// - Area protected only after passing protect.
// - Set features 90h with 01h enters OTP mode.
// - Set features 90h with all zero leaves mode.
// - Reset FFh leaves mode, falls back to async.
// - Program beyond range: short busy, protect flag 0.
package otpac_pkg;
   localparam logic [7:0] CMD_READ1     = 8'h00;
   localparam logic [7:0] CMD_READ2     = 8'h30;
   localparam logic [7:0] CMD_RCOL1     = 8'h05;
   localparam logic [7:0] CMD_RCOL2     = 8'he0;
   localparam logic [7:0] CMD_PROG1     = 8'h80;
   localparam logic [7:0] CMD_PROG2     = 8'h10;
   localparam logic [7:0] CMD_WCOL      = 8'h85;
   localparam logic [7:0] CMD_STATUS    = 8'h70;
   localparam logic [7:0] CMD_SETFEAT   = 8'hef;
   localparam logic [7:0] CMD_RESET     = 8'hff;
   localparam logic [7:0] CMD_SRESET    = 8'hfc;
   localparam logic [7:0] FEAT_OTP      = 8'h90;
   localparam logic [7:0] FEAT_OTP_ON   = 8'h01;
   localparam logic [7:0] PROTECT_PAGE  = 8'h01;
   localparam logic [7:0] START_PAGE    = 8'h02;
   localparam int         OTP_PAGES     = 30;
   localparam int         PARTIAL_PROGRAM_LIMIT = 2;
   localparam logic [7:0] STATUS_LOCKED = 8'h60;
   localparam int         ADDR_CYCLES   = 5;
   // Status bit positions.
   localparam int         ST_FAIL       = 0;
   localparam int         ST_ARRAY_READY_FLAG       = 5;
   localparam int         ST_RDY        = 6;
   localparam int         ST_WP         = 7;
   // Times in ns, cycle counts derived at 50 ns per clock.
   localparam int         CLK_NS        = 50;
   localparam int         PROGRAM_TIME_NS   = 1300000;
   localparam int         OTP_BUSY_TIME_NS  = 1000;
   localparam int         PAGE_READ_TIME_NS = 90000;
   localparam int         PROGRAM_CYC   = (PROGRAM_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int         OTP_BUSY_CYC  = (OTP_BUSY_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int         PAGE_READ_CYC = (PAGE_READ_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int         COL_W         = 14;
   localparam int         PAGE_BYTES    = 8936;
endpackage : otpac_pkg

/* File: src/otpac_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface otpac_if;
   logic       cle;
   logic       ale;
   logic       we;
   logic       re;
   logic [7:0] dq_h2d;
   logic [7:0] dq_d2h;
   logic       dq_d2h_oe;
   logic       ready_busy_n;
   modport dev  (input cle, ale, we, re, dq_h2d, output dq_d2h, dq_d2h_oe, ready_busy_n);
   modport host (output cle, ale, we, re, dq_h2d, input dq_d2h, dq_d2h_oe, ready_busy_n);
endinterface : otpac_if
`default_nettype wire

/* File: src/otpac_host.sv */
`timescale 1ns/1ns
`default_nettype none
module otpac_host (
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Link.
   otpac_if.host           nand_if,
   // User cycle request: kind 0 command, 1 address, 2 data in, 3 data out.
   input  wire logic       req_i,
   input  wire logic [1:0] kind_i,
   input  wire logic [7:0] byte_i,
   output logic            ack_o,
   output logic [7:0]      rdata_o,
   output logic            ready_o
);
   // The host by issuing only those byte sequences.
   logic rb_s1_q;
   logic rb_s2_q;
   logic rd_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
      end else begin
         rb_s1_q <= nand_if.ready_busy_n;
         rb_s2_q <= rb_s1_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nand_if.cle <= 1'b0;
         nand_if.ale <= 1'b0;
         nand_if.we  <= 1'b0;
         nand_if.re  <= 1'b0;
         nand_if.dq_h2d <= 8'h00;
         ack_o <= 1'b0;
         rd_q <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         nand_if.cle <= req_i && kind_i == 2'd0;
         nand_if.ale <= req_i && kind_i == 2'd1;
         nand_if.we  <= req_i && kind_i != 2'd3;
         nand_if.re  <= req_i && kind_i == 2'd3;
         nand_if.dq_h2d <= byte_i;
         rd_q  <= nand_if.re;
         ack_o <= req_i;
         if (rd_q) rdata_o <= nand_if.dq_d2h;
      end
   end

   assign ready_o = rb_s2_q;
endmodule : otpac_host
`default_nettype wire

/* File: verification/otpac_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module otpac_monitor #(
   parameter int PROGRAM_CYC   = 20,
   parameter int OTP_BUSY_CYC  = 20,
   parameter int PAGE_READ_CYC = 20
) (
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Link.
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we,
   input  wire logic       re,
   input  wire logic [7:0] dq_h2d,
   input  wire logic [7:0] dq_d2h,
   input  wire logic       dq_d2h_oe,
   input  wire logic       ready_busy_n
);
   logic [7:0]  last_cmd_q;
   logic [15:0] low_cnt_q;
   // The device drops command, address and data-in cycles while busy except status requests, so only taken ones count.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_cmd_q <= 8'h00;
      end else if (we && cle && (ready_busy_n || dq_h2d == 8'h70)) begin
         last_cmd_q <= dq_h2d;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         low_cnt_q <= 16'h0000;
      end else begin
         low_cnt_q <= ready_busy_n ? 16'h0000 : low_cnt_q + 16'h0001;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_prog_start;
      we && cle && dq_h2d == 8'h10 && ready_busy_n |-> ##[1:3] !ready_busy_n;
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("no busy after confirm");
   property p_read_start;
      we && cle && dq_h2d == 8'h30 && ready_busy_n |-> ##[1:3] !ready_busy_n;
   endproperty
   a_read_start: assert property (p_read_start) else $error("no busy after read");
   property p_prog_len;
      ready_busy_n && low_cnt_q != 16'h0000 && last_cmd_q == 8'h10
         |-> low_cnt_q == PROGRAM_CYC || low_cnt_q == OTP_BUSY_CYC;
   endproperty
   a_prog_len: assert property (p_prog_len) else $error("program busy length wrong");
   property p_read_len;
      ready_busy_n && low_cnt_q != 16'h0000 && last_cmd_q == 8'h30 |-> low_cnt_q == PAGE_READ_CYC;
   endproperty
   a_read_len: assert property (p_read_len) else $error("read busy length wrong");
   property p_rdy_bit;
      re && last_cmd_q == 8'h70 |=> dq_d2h[6] == $past(ready_busy_n);
   endproperty
   a_rdy_bit: assert property (p_rdy_bit) else $error("ready bit differs from pin");
   property p_array_ready_flag_bit;
      re && last_cmd_q == 8'h70 |=> dq_d2h[5] == $past(ready_busy_n);
   endproperty
   a_array_ready_flag_bit: assert property (p_array_ready_flag_bit) else $error("array ready bit wrong");
   property p_fall_cause;
      $fell(ready_busy_n) |-> last_cmd_q inside {8'h10, 8'h30, 8'hff, 8'hfc};
   endproperty
   a_fall_cause: assert property (p_fall_cause) else $error("busy without cause");
   property p_reset_ready;
      !$past(rst_b_i) |-> ready_busy_n && !dq_d2h_oe;
   endproperty
   a_reset_ready: assert property (p_reset_ready) else $error("not ready after reset");
   property p_latch_excl;
      !(cle && ale) && !(we && re);
   endproperty
   a_latch_excl: assert property (p_latch_excl) else $error("strobes overlap");
endmodule : otpac_monitor
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int PROG_N = 20;
   localparam int OBSY_N = 6;
   localparam int READ_N = 12;
   logic       clk_i = 1'b0;
   logic       rst_b_i = 1'b0;
   logic       req_i = 1'b0;
   logic [1:0] kind_i = 2'h0;
   logic [7:0] byte_i = 8'h00;
   logic       ack_o;
   logic [7:0] rdata_o;
   logic       ready_o;
   logic       otp_mode_o;
   logic       sync_if_o;
   logic       protected_o;
   int         n_fail = 0;
   int         n_tests = 0;
   int         lo_n = 0;
   int         busy_len = 0;
   otpac_if link ();
   otpac_device #(.PROGRAM_CYC(PROG_N), .OTP_BUSY_CYC(OBSY_N), .PAGE_READ_CYC(READ_N))
      i_otpac_device (.clk_i(clk_i), .rst_b_i(rst_b_i), .nand_if(link),
      .otp_mode_o(otp_mode_o), .sync_if_o(sync_if_o), .protected_o(protected_o));
   otpac_host i_otpac_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .nand_if(link), .req_i(req_i),
      .kind_i(kind_i), .byte_i(byte_i), .ack_o(ack_o), .rdata_o(rdata_o), .ready_o(ready_o));
   otpac_monitor #(.PROGRAM_CYC(PROG_N), .OTP_BUSY_CYC(OBSY_N), .PAGE_READ_CYC(READ_N))
      i_otpac_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i), .cle(link.cle), .ale(link.ale),
      .we(link.we), .re(link.re), .dq_h2d(link.dq_h2d), .dq_d2h(link.dq_d2h),
      .dq_d2h_oe(link.dq_d2h_oe), .ready_busy_n(link.ready_busy_n));
   always #25 clk_i = ~clk_i;
   // Busy spans are measured on the user side, so the ends must agree on the pin.
   always @(posedge clk_i) begin
      if (ready_o === 1'b0) begin
         lo_n <= lo_n + 1;
      end else if (lo_n != 0) begin
         busy_len <= lo_n;
         lo_n <= 0;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input logic [9:0] op);
      int i;
      @(posedge clk_i);
      req_i <= 1'b1;
      {kind_i, byte_i} <= op;
      @(posedge clk_i);
      req_i <= 1'b0;
      #1;
      for (i = 0; i < 4 && ack_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      if (ack_o !== 1'b1) chk(ack_o, 1'b1);
      // Strobe, device data and host capture take one cycle each.
      repeat (3) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic ops(input logic [9:0] seq[]);
      foreach (seq[i]) cyc(seq[i]);
   endtask : ops
   task automatic dout(input logic [7:0] exp);
      cyc(10'h300);
      chk(rdata_o, exp);
   endtask : dout
   task automatic status(input logic [7:0] exp);
      cyc(10'h070);
      dout(exp);
   endtask : status
   task automatic wait_busy(input int exp);
      int i;
      for (i = 0; i < 300 && busy_len == 0; i++) @(posedge clk_i);
      #1;
      chk(busy_len, exp);
      busy_len = 0;
   endtask : wait_busy
   task automatic setfeat(input logic [7:0] p1);
      ops('{10'h0ef, 10'h190, {2'd2, p1}, 10'h200, 10'h200, 10'h200});
   endtask : setfeat
   task automatic prog1(input logic [7:0] page, input logic [7:0] d);
      ops('{10'h080, 10'h100, 10'h100, {2'd1, page}, 10'h100, 10'h100, {2'd2, d}, 10'h010});
   endtask : prog1
   task automatic t_program;
      chk(otp_mode_o, 1'b0);
      setfeat(8'h01);
      chk(otp_mode_o, 1'b1);
      ops('{10'h080, 10'h100, 10'h100, 10'h102, 10'h100, 10'h100, 10'h2a5, 10'h23c,
            10'h085, 10'h104, 10'h100, 10'h277, 10'h010});
      status(8'h80);
      wait_busy(PROG_N);
      status(8'he0);
      chk(protected_o, 1'b0);
      prog1(8'h1f, 8'h5a);
      wait_busy(PROG_N);
      prog1(8'h20, 8'h5a);
      wait_busy(OBSY_N);
      cyc(10'h070);
      cyc(10'h300);
      chk(rdata_o[7], 1'b0);
      $display("t_program done");
   endtask : t_program
   task automatic t_read;
      ops('{10'h000, 10'h100, 10'h100, 10'h102, 10'h100, 10'h100, 10'h030});
      wait_busy(READ_N);
      dout(8'ha5);
      dout(8'h3c);
      ops('{10'h005, 10'h104, 10'h100, 10'h0e0});
      dout(8'h77);
      ops('{10'h000, 10'h101, 10'h100, 10'h102, 10'h100, 10'h100, 10'h030});
      wait_busy(READ_N);
      status(8'he0);
      cyc(10'h000);
      dout(8'h3c);
      $display("t_read done");
   endtask : t_read
   task automatic t_protect;
      prog1(8'h01, 8'h00);
      wait_busy(PROG_N);
      status(8'he0);
      chk(protected_o, 1'b1);
      prog1(8'h02, 8'h00);
      wait_busy(OBSY_N);
      status(8'h60);
      prog1(8'h01, 8'h00);
      wait_busy(OBSY_N);
      status(8'h60);
      $display("t_protect done");
   endtask : t_protect
   task automatic t_modes;
      setfeat(8'h00);
      chk(otp_mode_o, 1'b0);
      setfeat(8'h01);
      cyc(10'h0fc);
      repeat (40) @(posedge clk_i);
      chk(otp_mode_o, 1'b0);
      chk(sync_if_o, 1'b1);
      setfeat(8'h01);
      cyc(10'h0ff);
      repeat (40) @(posedge clk_i);
      chk(otp_mode_o, 1'b0);
      chk(sync_if_o, 1'b0);
      $display("t_modes done");
   endtask : t_modes
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      busy_len = 0;
      t_program();
      t_read();
      t_protect();
      t_modes();
      complete_run();
   end
   initial begin
      #(50 * 20000);
      n_fail++;
      complete_run();
   end
endmodule : tb
`default_nettype wire
